// File: gcsr_regs.sv
`timescale 1ns/1ps

// Functional notes
// - overflow flag bit 7 sets on overrun, clears only on buffer config write.
// - status bits 6..0 give frames held, zero when empty.
// - fill count returns to zero when drained or on buffer config write.
// - range code 0..4 selects full scale 2000 down to 125 dps.
// - bandwidth code 0..7 selects output rate and filter cutoff.
// - bandwidth bit 7 is read-only one; register reads 0x80 after reset.
// - power codes 0x00 normal, 0x80 suspend, 0x20 deep suspend; resets normal.
// - reset command write-only; only key 0xB6 starts a reset.
// - after accepted key, wait 30 ms then restore configuration defaults.
// - reset key is accepted in every power and operating state.
// - interrupt control bit 7 enables data-ready interrupt; resets zero.
// - interrupt control bit 6 enables buffer interrupt; bits 5..0 reserved.
// - buffer config write empties buffer, clears full and overflow flags.
module gcsr_regs #(
    parameter int FILL_DEPTH = 127,
    parameter int RESTORE_CYC = gcsr_pkg::RESTORE_DELAY_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic        frame_push,
    input  wire logic        frame_pop,
    input  wire logic        new_sample,
    input  wire logic        buffer_event,
    output logic [2:0]       full_scale_code,
    output logic [6:0]       filter_rate_code,
    output logic [7:0]       power_state_code,
    output gcsr_pkg::gcsr_pm_t power_mode,
    output logic             buffer_flush,
    output logic             soft_reset_busy,
    output logic             data_ready_irq,
    output logic             buffer_irq
);

    // ************************************************************
    // bus handshake: one wait cycle, then the answer
    // ************************************************************
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  resp_q;
    logic [1:0]  resp_d;
    logic        req;
    logic        take;
    logic [7:0]  index;
    logic [7:0]  wbyte;
    logic        lane0;

    assign req   = avs_read || avs_write;
    assign take  = req && !ack_q;                           // edge at which request is handled
    assign index = avs_address[9:2];
    assign wbyte = avs_writedata[7:0];
    assign lane0 = avs_byteenable[0];

    // ************************************************************
    // configuration storage
    // ************************************************************
    logic [7:0] range_q;
    logic [7:0] range_d;
    logic [6:0] filter_q;
    logic [6:0] filter_d;
    logic [7:0] power_q;
    logic [7:0] power_d;
    logic [1:0] inten_q;
    logic [1:0] inten_d;
    logic       flush_q;
    logic       flush_d;
    logic       key_hit;
    logic       restore;
    logic [6:0] fill_count;
    logic       overrun;

    // register map lookup; used only for the error response of reads and writes
    function automatic logic is_mapped(input logic [7:0] idx);
        if (idx == gcsr_pkg::REG_BUFFER_FILL_STATUS) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_RATE_FULL_SCALE_SELECT) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_RATE_FILTER_ODR_SELECT) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_POWER_STATE_SELECT) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_KEYED_RESET_COMMAND) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_INTERRUPT_SOURCE_ENABLE) begin
            return 1'b1;
        end else if (idx == gcsr_pkg::REG_BUFFER_CONFIG_1) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // accepted key detection, any power state
    assign key_hit = take && avs_write && lane0
                     && index == gcsr_pkg::REG_KEYED_RESET_COMMAND
                     && wbyte == gcsr_pkg::RESET_KEY;

    // ************************************************************
    // register writes and restore
    // ************************************************************
    always_comb begin
        range_d  = range_q;
        filter_d = filter_q;
        power_d  = power_q;
        inten_d  = inten_q;
        flush_d  = 1'b0;
        if (restore) begin
            range_d  = gcsr_pkg::RANGE_RESET;
            filter_d = gcsr_pkg::FILTER_CODE_RESET;
            power_d  = gcsr_pkg::POWER_NORMAL;
            inten_d  = gcsr_pkg::INT_ENABLE_RESET;
        end else if (take && avs_write && lane0) begin
            if (index == gcsr_pkg::REG_RATE_FULL_SCALE_SELECT) begin
                range_d = wbyte;
            end else if (index == gcsr_pkg::REG_RATE_FILTER_ODR_SELECT) begin
                filter_d = wbyte[6:0];
            end else if (index == gcsr_pkg::REG_POWER_STATE_SELECT) begin
                power_d = wbyte;
            end else if (index == gcsr_pkg::REG_INTERRUPT_SOURCE_ENABLE) begin
                inten_d = wbyte[7:6];
            end else if (index == gcsr_pkg::REG_BUFFER_CONFIG_1) begin
                flush_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            range_q  <= gcsr_pkg::RANGE_RESET;
            filter_q <= gcsr_pkg::FILTER_CODE_RESET;
            power_q  <= gcsr_pkg::POWER_NORMAL;
            inten_q  <= gcsr_pkg::INT_ENABLE_RESET;
            flush_q  <= 1'b0;
        end else begin
            range_q  <= range_d;
            filter_q <= filter_d;
            power_q  <= power_d;
            inten_q  <= inten_d;
            flush_q  <= flush_d;
        end
    end

    // ************************************************************
    // read mux and bus answer
    // ************************************************************
    always_comb begin
        ack_d   = take;
        rdata_d = 32'h0000_0000;
        resp_d  = 2'h0;
        if (take && !is_mapped(index)) begin
            resp_d = 2'h2;                                  // unmapped: slave error
        end
        if (take && avs_read) begin
            if (index == gcsr_pkg::REG_BUFFER_FILL_STATUS) begin
                rdata_d[7:0] = {overrun, fill_count};
            end else if (index == gcsr_pkg::REG_RATE_FULL_SCALE_SELECT) begin
                rdata_d[7:0] = range_q;
            end else if (index == gcsr_pkg::REG_RATE_FILTER_ODR_SELECT) begin
                rdata_d[7:0] = {1'b1, filter_q};
            end else if (index == gcsr_pkg::REG_POWER_STATE_SELECT) begin
                rdata_d[7:0] = power_q;
            end else if (index == gcsr_pkg::REG_INTERRUPT_SOURCE_ENABLE) begin
                rdata_d[7:0] = {inten_q, 6'h00};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h0;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
        end
    end

    assign avs_waitrequest = !ack_q;
    assign avs_readdata    = rdata_q;
    assign avs_response    = resp_q;

    // ************************************************************
    // power mode decode; unknown codes leave the mode normal
    // ************************************************************
    always_comb begin
        if (power_q == gcsr_pkg::POWER_SUSPEND) begin
            power_mode = gcsr_pkg::GCSR_PM_SUSPEND;
        end else if (power_q == gcsr_pkg::POWER_DEEP_SUSPEND) begin
            power_mode = gcsr_pkg::GCSR_PM_DEEP;
        end else begin
            power_mode = gcsr_pkg::GCSR_PM_NORMAL;
        end
    end

    // ************************************************************
    // outputs to the sensor core
    // ************************************************************
    assign full_scale_code  = range_q[2:0];
    assign filter_rate_code = filter_q;
    assign power_state_code = power_q;
    assign buffer_flush     = flush_q;
    assign data_ready_irq   = inten_q[1] && new_sample;
    assign buffer_irq       = inten_q[0] && buffer_event;

    // ************************************************************
    // submodules
    // ************************************************************
    gcsr_fill_counter #(
        .DEPTH (FILL_DEPTH)
    ) u_fill (
        .core_clk   (core_clk),
        .reset      (reset),
        .frame_push (frame_push),
        .frame_pop  (frame_pop),
        .flush      (flush_d),
        .fill_count (fill_count),
        .overrun    (overrun)
    );

    gcsr_restore_timer #(
        .DELAY_CYC (RESTORE_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (key_hit),
        .busy     (soft_reset_busy),
        .restore  (restore)
    );

endmodule

// File: gcsr_pkg.sv
package gcsr_pkg;

    // ************************************************************
    // register offsets (byte addresses are index times four)
    // ************************************************************
    localparam logic [7:0] REG_BUFFER_FILL_STATUS      = 8'h0E;
    localparam logic [7:0] REG_RATE_FULL_SCALE_SELECT  = 8'h0F;
    localparam logic [7:0] REG_RATE_FILTER_ODR_SELECT  = 8'h10;
    localparam logic [7:0] REG_POWER_STATE_SELECT      = 8'h11;
    localparam logic [7:0] REG_KEYED_RESET_COMMAND     = 8'h14;
    localparam logic [7:0] REG_INTERRUPT_SOURCE_ENABLE = 8'h15;
    localparam logic [7:0] REG_BUFFER_CONFIG_1         = 8'h3E;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         OVERRUN_BIT        = 7;
    localparam int         DATA_READY_EN_BIT  = 7;
    localparam int         BUFFER_INT_EN_BIT  = 6;
    localparam int         FILTER_FIXED_BIT   = 7;
    localparam logic [7:0] RANGE_RESET        = 8'h00;
    localparam logic [7:0] RANGE_MAX_CODE     = 8'h04;
    localparam logic [7:0] FILTER_RESET       = 8'h80;
    localparam logic [6:0] FILTER_CODE_RESET  = 7'h00;
    localparam logic [7:0] POWER_NORMAL       = 8'h00;
    localparam logic [7:0] POWER_SUSPEND      = 8'h80;
    localparam logic [7:0] POWER_DEEP_SUSPEND = 8'h20;
    localparam logic [1:0] INT_ENABLE_RESET   = 2'h0;
    localparam logic [7:0] RESET_KEY          = 8'hB6;
    localparam logic [6:0] FILL_EMPTY         = 7'h00;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLOCK_HZ           = 100_000_000;
    localparam int RESTORE_DELAY_MS   = 30;
    localparam int RESTORE_DELAY_CYC  = CLOCK_HZ / 1000 * RESTORE_DELAY_MS;

    // power modes decoded from the power register
    typedef enum logic [1:0] {
        GCSR_PM_NORMAL,
        GCSR_PM_SUSPEND,
        GCSR_PM_DEEP
    } gcsr_pm_t;

endpackage

// File: gcsr_fill_counter.sv
`timescale 1ns/1ps

// ************************************************************
// buffer fill level and overrun tracking
// ************************************************************
module gcsr_fill_counter #(
    parameter int DEPTH = 127
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       frame_push,
    input  wire logic       frame_pop,
    input  wire logic       flush,
    output logic [6:0]      fill_count,
    output logic            overrun
);

    localparam logic [6:0] FULL = 7'(DEPTH);

    logic [6:0] count_q;
    logic [6:0] count_d;
    logic       overrun_q;
    logic       overrun_d;

    // next count and sticky overrun; an overrun seen with a flush survives
    always_comb begin
        count_d   = count_q;
        overrun_d = overrun_q;
        if (flush) begin
            count_d   = gcsr_pkg::FILL_EMPTY;
            overrun_d = 1'b0;
        end else if (frame_push && !frame_pop && count_q != FULL) begin
            count_d = count_q + 7'h01;
        end else if (frame_pop && !frame_push && count_q != gcsr_pkg::FILL_EMPTY) begin
            count_d = count_q - 7'h01;
        end
        if (frame_push && !frame_pop && count_q == FULL) begin
            overrun_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q   <= gcsr_pkg::FILL_EMPTY;
            overrun_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            overrun_q <= overrun_d;
        end
    end

    assign fill_count = count_q;
    assign overrun    = overrun_q;

endmodule

// File: gcsr_restore_timer.sv
`timescale 1ns/1ps

// ************************************************************
// delay from accepted reset key to restore pulse
// ************************************************************
module gcsr_restore_timer #(
    parameter int DELAY_CYC = gcsr_pkg::RESTORE_DELAY_CYC
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      busy,
    output logic      restore
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        busy_q;
    logic        busy_d;
    logic        restore_q;
    logic        restore_d;

    // a new key while counting restarts the wait
    always_comb begin
        cnt_d     = cnt_q;
        busy_d    = busy_q;
        restore_d = 1'b0;
        if (start) begin
            cnt_d  = 32'(DELAY_CYC - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == 32'h0000_0000) begin
                busy_d    = 1'b0;
                restore_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q     <= 32'h0000_0000;
            busy_q    <= 1'b0;
            restore_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            busy_q    <= busy_d;
            restore_q <= restore_d;
        end
    end

    assign busy    = busy_q;
    assign restore = restore_q;

endmodule

// File: gcsr_regs_asserts.sv
`timescale 1ns/1ps

// ************************************************************
// port checks for the gyro register bank
// ************************************************************
module gcsr_regs_asserts #(
    parameter int RESTORE_CYC = 20
) (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire logic [9:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [3:0]         avs_byteenable,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire logic               new_sample,
    input wire logic               buffer_event,
    input wire logic [2:0]         full_scale_code,
    input wire logic [6:0]         filter_rate_code,
    input wire logic [7:0]         power_state_code,
    input wire gcsr_pkg::gcsr_pm_t power_mode,
    input wire logic               buffer_flush,
    input wire logic               soft_reset_busy,
    input wire logic               data_ready_irq,
    input wire logic               buffer_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // write taken on lane 0, and a key write
    wire logic wr_take = avs_write && avs_waitrequest && avs_byteenable[0];
    wire logic key_take = wr_take && avs_address[9:2] == 8'h14;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    // counts cycles of the restore wait
    always_comb begin
        busy_cnt_d = busy_cnt_q;
        if (key_take && avs_writedata[7:0] == 8'hB6) begin
            busy_cnt_d = 32'h0;
        end else if (soft_reset_busy) begin
            busy_cnt_d = busy_cnt_q + 32'h1;
        end
    end

    // registers the wait counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // named sequences: read answer and flush pulse
    sequence s_answer;
        avs_read && !avs_waitrequest;
    endsequence
    sequence s_flush_pulse;
        buffer_flush ##1 !buffer_flush;
    endsequence

    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low without request");
    a_read_upper: assert property (s_answer |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_filter_fixed: assert property (s_answer and avs_address[9:2] == 8'h10 |->
        avs_readdata[7:0] == {1'b1, filter_rate_code}) else $error("bandwidth read wrong");
    a_flush_pulse: assert property (wr_take && avs_address[9:2] == 8'h3E |=> s_flush_pulse)
        else $error("flush pulse missing");
    a_key_start: assert property (key_take && avs_writedata[7:0] == 8'hB6 |=> soft_reset_busy)
        else $error("key did not start reset");
    a_key_ignore: assert property (key_take && avs_writedata[7:0] != 8'hB6
        && !soft_reset_busy |=> !soft_reset_busy) else $error("wrong key started reset");
    a_restore_time: assert property ($fell(soft_reset_busy) |->
        busy_cnt_q == RESTORE_CYC) else $error("restore wait length");
    a_restore_cfg: assert property ($fell(soft_reset_busy) |-> ##1
        (full_scale_code == 3'h0 && filter_rate_code == 7'h00 && power_state_code == 8'h00))
        else $error("defaults not restored");
    a_power_decode: assert property (power_state_code == 8'h20 |->
        power_mode == gcsr_pkg::GCSR_PM_DEEP) else $error("deep decode");
    a_power_susp: assert property (power_state_code == 8'h80 |->
        power_mode == gcsr_pkg::GCSR_PM_SUSPEND) else $error("suspend decode");
    a_drdy_gate: assert property (!new_sample |-> !data_ready_irq)
        else $error("data ready irq without sample");
    a_buf_gate: assert property (!buffer_event |-> !buffer_irq)
        else $error("buffer irq without event");
endmodule

bind gcsr_regs gcsr_regs_asserts #(.RESTORE_CYC(RESTORE_CYC)) gcsr_regs_asserts_i (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .new_sample(new_sample),
    .buffer_event(buffer_event), .full_scale_code(full_scale_code),
    .filter_rate_code(filter_rate_code), .power_state_code(power_state_code),
    .power_mode(power_mode), .buffer_flush(buffer_flush), .soft_reset_busy(soft_reset_busy),
    .data_ready_irq(data_ready_irq), .buffer_irq(buffer_irq));

// File: gcsr_regs_tb_top.sv
`timescale 1ns/1ps

// ************************************************************
// register bank bench
// ************************************************************
module gcsr_regs_tb_top;
    localparam int RCYC = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic frame_push = 1'b0;
    logic frame_pop = 1'b0;
    logic new_sample = 1'b0;
    logic buffer_event = 1'b0;
    logic [2:0] full_scale_code;
    logic [6:0] filter_rate_code;
    logic [7:0] power_state_code;
    gcsr_pkg::gcsr_pm_t power_mode;
    logic buffer_flush;
    logic soft_reset_busy;
    logic data_ready_irq;
    logic buffer_irq;
    logic [31:0] rd_q;
    logic [1:0] rsp_q;
    logic [7:0] pw [5] = '{8'h00, 8'h80, 8'h00, 8'h20, 8'h00};
    logic [1:0] pm [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;
    int n;

    gcsr_regs #(.RESTORE_CYC(RCYC)) gcsr_regs_i (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .frame_push(frame_push), .frame_pop(frame_pop),
        .new_sample(new_sample), .buffer_event(buffer_event), .full_scale_code(full_scale_code),
        .filter_rate_code(filter_rate_code), .power_state_code(power_state_code),
        .power_mode(power_mode), .buffer_flush(buffer_flush), .soft_reset_busy(soft_reset_busy),
        .data_ready_irq(data_ready_irq), .buffer_irq(buffer_irq));

    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // prints counts and verdict
    task conclude;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // compares one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest low
    task acc(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        int k;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        k = 0;
        // waitrequest is sampled at the rising edge; data taken at that same edge
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 200);
        if (k >= 200) chk(32'h1, 32'h0);
        rd_q = avs_readdata;
        rsp_q = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d, 4'h1);
    endtask

    task rdc(input logic [7:0] idx, input logic [31:0] exp);
        acc(1'b0, idx, 8'h00, 4'hF);
        chk(rd_q, exp);
    endtask

    // n cycles of push or pop pulses
    task frames(input int cnt, input logic pop);
        repeat (cnt) begin
            @(posedge core_clk);
            frame_push <= !pop;
            frame_pop <= pop;
        end
        @(posedge core_clk);
        frame_push <= 1'b0;
        frame_pop <= 1'b0;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    // test sequence
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rdc(8'h0E, 32'h00);
        rdc(8'h0F, 32'h00);
        rdc(8'h10, 32'h80);
        rdc(8'h11, 32'h00);
        rdc(8'h15, 32'h00);
        for (i = 0; i < 5; i++) begin
            wr(8'h0F, 8'(i));
            rdc(8'h0F, 32'(i));
            chk(32'(full_scale_code), 32'(i));
        end
        for (i = 0; i < 8; i++) begin
            wr(8'h10, 8'(i));
            rdc(8'h10, 32'h80 | 32'(i));
            chk(32'(filter_rate_code), 32'(i));
        end
        // only normal to and from a suspend state
        for (i = 0; i < 5; i++) begin
            wr(8'h11, pw[i]);
            rdc(8'h11, 32'(pw[i]));
            chk(32'(power_mode), 32'(pm[i]));
            chk(32'(power_state_code), 32'(pw[i]));
        end
        wr(8'h15, 8'hFF);
        rdc(8'h15, 32'hC0);
        new_sample <= 1'b1;
        buffer_event <= 1'b1;
        @(negedge core_clk);
        chk(32'(data_ready_irq), 32'h1);
        chk(32'(buffer_irq), 32'h1);
        wr(8'h15, 8'h80);
        chk(32'(buffer_irq), 32'h0);
        chk(32'(data_ready_irq), 32'h1);
        wr(8'h15, 8'h00);
        chk(32'(data_ready_irq), 32'h0);
        acc(1'b1, 8'h0F, 8'h03, 4'h0);
        rdc(8'h0F, 32'h04);
        rdc(8'h20, 32'h00);
        chk(32'(rsp_q), 32'h2);
        frames(5, 1'b0);
        rdc(8'h0E, 32'h05);
        frames(5, 1'b1);
        rdc(8'h0E, 32'h00);
        frames(128, 1'b0);
        rdc(8'h0E, 32'hFF);
        frames(1, 1'b1);
        rdc(8'h0E, 32'hFE);
        wr(8'h3E, 8'h00);
        rdc(8'h0E, 32'h00);
        wr(8'h0F, 8'h03);
        wr(8'h10, 8'h05);
        wr(8'h11, 8'h80);
        wr(8'h15, 8'hC0);
        wr(8'h14, 8'h55);
        chk(32'(soft_reset_busy), 32'h0);
        rdc(8'h0F, 32'h03);
        wr(8'h14, 8'hB6);
        chk(32'(soft_reset_busy), 32'h1);
        n = 0;
        while (soft_reset_busy !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(soft_reset_busy), 32'h0);
        chk(32'(n), 32'(RCYC));
        rdc(8'h0F, 32'h00);
        rdc(8'h10, 32'h80);
        rdc(8'h11, 32'h00);
        rdc(8'h15, 32'h00);
        // key accepted in deep suspend too
        wr(8'h11, 8'h20);
        chk(32'(power_mode), 32'h2);
        wr(8'h14, 8'hB6);
        chk(32'(soft_reset_busy), 32'h1);
        repeat (RCYC + 2) @(posedge core_clk);
        rdc(8'h11, 32'h00);
        conclude();
    end
endmodule
